// ==== design/tcs_defs.svh ====
// Register indices, field positions, reset values and divider counts.
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define TCS_IDX_T0_LOW 8'h8A
`define TCS_IDX_T1_LOW 8'h8B
`define TCS_IDX_T0_HIGH 8'h8C
`define TCS_IDX_T1_HIGH 8'h8D
`define TCS_IDX_CLK_CFG 8'h8E
`define TCS_IDX_TIMER_CTRL 8'h90
`define TCS_IDX_IRQ_STATUS 8'h91
`define TCS_IDX_IRQ_MASK 8'h92

// ==========================================================================
// Field positions
`define TCS_CFG_T1_SEL 3
`define TCS_CFG_T0_SEL 2
`define TCS_CFG_WMASK 8'h0F
`define TCS_CTRL_RUN0 0
`define TCS_CTRL_TIMER_ZERO_GATE 1
`define TCS_CTRL_RUN1 4
`define TCS_CTRL_GATE1 5

// ==========================================================================
// Reset values
`define TCS_RST_BYTE 8'h00
`define TCS_RST_FLAGS 2'h0

// ==========================================================================
// Prescaler terminal counts (period minus one)
`define TCS_DIV12_TERM 6'h0B
`define TCS_DIV4_TERM 6'h03
`define TCS_DIV48_TERM 6'h2F
`define TCS_EXT8_TERM 6'h07

`endif

// ==== design/tcs_pkg.sv ====
// Types shared by the timer clock select and count block.
package tcs_pkg;

  // ========================================================================
  // Timer operating modes
  typedef enum logic [1:0] {
    TCS_MODE_13BIT,
    TCS_MODE_16BIT,
    TCS_MODE_RELOAD,
    TCS_MODE_SPLIT
  } tcs_mode_t;

endpackage

// ==== design/tcs_prescaler.sv ====
// Shared prescaler producing one tick pulse per prescaled clock period.
`timescale 1ns/1ps
`include "tcs_defs.svh"

module tcs_prescaler (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [1:0] i_prescale_field,
  input wire logic i_ext_clk,
  output logic o_tick
);

  // ========================================================================
  // State
  logic ext_meta_reg, ext_meta_next;
  logic ext_sync_reg, ext_sync_next;
  logic ext_prev_reg, ext_prev_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [1:0] field_reg, field_next;
  logic tick_reg, tick_next;
  logic [6:0] since_reg, since_next;
  logic clean_reg, clean_next;
  logic [5:0] term;
  logic adv;

  // ========================================================================
  // Next state
  always_comb begin
    ext_meta_next = i_ext_clk;
    ext_sync_next = ext_meta_reg;
    ext_prev_next = ext_sync_reg;
    field_next = i_prescale_field;
    if (i_prescale_field == 2'h0) begin
      term = `TCS_DIV12_TERM;
    end else if (i_prescale_field == 2'h1) begin
      term = `TCS_DIV4_TERM;
    end else if (i_prescale_field == 2'h2) begin
      term = `TCS_DIV48_TERM;
    end else begin
      term = `TCS_EXT8_TERM;
    end
    // External clock advances only on a synchronised rising edge.
    adv = (i_prescale_field == 2'h3) ? (ext_sync_reg & ~ext_prev_reg) : 1'b1;
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (i_prescale_field != field_reg) begin
      cnt_next = 6'h00;
    end else if (adv) begin
      if (cnt_reg >= term) begin
        cnt_next = 6'h00;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 6'h01;
      end
    end
    since_next = (since_reg == 7'h7F) ? since_reg : since_reg + 7'h01;
    clean_next = clean_reg;
    if (i_prescale_field != field_reg) begin
      clean_next = 1'b0;
    end else if (tick_reg) begin
      since_next = 7'h00;
      clean_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      cnt_reg <= 6'h00;
      field_reg <= 2'h0;
      tick_reg <= 1'b0;
      since_reg <= 7'h00;
      clean_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_meta_next;
      ext_sync_reg <= ext_sync_next;
      ext_prev_reg <= ext_prev_next;
      cnt_reg <= cnt_next;
      field_reg <= field_next;
      tick_reg <= tick_next;
      since_reg <= since_next;
      clean_reg <= clean_next;
    end
  end

  assign o_tick = tick_reg;

  // ========================================================================
  // Checks
  property p_div_period;
    @(posedge i_clk) disable iff (i_srst)
    (o_tick && clean_reg && i_prescale_field != 2'h3
      && i_prescale_field == field_reg)
      |-> (since_reg == {1'b0, term});
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("Prescaled tick spacing wrong.");

  property p_tick_pulse;
    @(posedge i_clk) disable iff (i_srst)
    o_tick |=> !o_tick ##1 !o_tick ##1 !o_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("Prescaled ticks closer than four cycles.");

endmodule // tcs_prescaler

// ==== design/tcs_top.sv ====
// Two timers with clock select, shared prescaler and AHB-Lite registers.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "tcs_defs.svh"

module tcs_top import tcs_pkg::*; (
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_EXT_CLK,
  input wire logic I_EXT_GATE_ZERO,
  input wire logic I_EXT_GATE_ONE,
  input wire logic I_T0_VECTORED,
  input wire logic I_T1_VECTORED,
  output logic O_T0_OVERFLOW_FLAG,
  output logic O_T1_OVERFLOW_FLAG,
  output logic O_IRQ
);

  // ========================================================================
  // State
  logic [7:0] t0l_reg, t0l_next;
  logic [7:0] t0h_reg, t0h_next;
  logic [7:0] t1l_reg, t1l_next;
  logic [7:0] t1h_reg, t1h_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [1:0] flag_reg, flag_next;
  logic [1:0] mask_reg, mask_next;
  logic irq_reg, irq_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic hready_reg;
  logic hresp_reg;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_idx_reg, wr_idx_next;

  logic pre_tick;
  logic tick0, tick1, en0, en1, en_split_high;
  logic ovf0, ovf1;
  logic acc, addr_ok, rd_acc;
  logic [7:0] rd_idx;
  logic wr_t0l, wr_t0h, wr_t1l, wr_t1h, wr_cfg, wr_ctrl, wr_stat, wr_mask;
  logic [16:0] step0, step1;
  tcs_mode_t mode0, mode1;

  // ========================================================================
  // Shared prescaler
  tcs_prescaler u_prescaler (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_prescale_field(cfg_reg[1:0]),
    .i_ext_clk(I_EXT_CLK),
    .o_tick(pre_tick)
  );

  // ========================================================================
  // One count step for modes other than split.
  function automatic logic [16:0] tcs_step(input tcs_mode_t mode,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    c16 = {1'b0, hi, lo} + 17'h00001;
    c8 = {1'b0, lo} + 9'h001;
    case (mode)
      TCS_MODE_13BIT: tcs_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      TCS_MODE_16BIT: tcs_step = c16;
      TCS_MODE_RELOAD: tcs_step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
      default: tcs_step = {1'b0, hi, lo};
    endcase
  endfunction

  // ========================================================================
  // Bus decode
  always_comb begin
    acc = I_HSEL & I_HREADY & I_HTRANS[1];
    addr_ok = (I_HADDR[31:10] == 22'h000000);
    rd_acc = acc & ~I_HWRITE & addr_ok;
    rd_idx = I_HADDR[9:2];
    wr_pend_next = acc & I_HWRITE & addr_ok;
    wr_idx_next = I_HADDR[9:2];
    wr_t0l = wr_pend_reg && (wr_idx_reg == `TCS_IDX_T0_LOW);
    wr_t1l = wr_pend_reg && (wr_idx_reg == `TCS_IDX_T1_LOW);
    wr_t0h = wr_pend_reg && (wr_idx_reg == `TCS_IDX_T0_HIGH);
    wr_t1h = wr_pend_reg && (wr_idx_reg == `TCS_IDX_T1_HIGH);
    wr_cfg = wr_pend_reg && (wr_idx_reg == `TCS_IDX_CLK_CFG);
    wr_ctrl = wr_pend_reg && (wr_idx_reg == `TCS_IDX_TIMER_CTRL);
    wr_stat = wr_pend_reg && (wr_idx_reg == `TCS_IDX_IRQ_STATUS);
    wr_mask = wr_pend_reg && (wr_idx_reg == `TCS_IDX_IRQ_MASK);
  end

  // ========================================================================
  // Timers, configuration and flags
  always_comb begin
    mode0 = tcs_mode_t'(ctrl_reg[3:2]);
    mode1 = tcs_mode_t'(ctrl_reg[7:6]);
    tick0 = cfg_reg[`TCS_CFG_T0_SEL] | pre_tick;
    tick1 = cfg_reg[`TCS_CFG_T1_SEL] | pre_tick;
    en0 = ctrl_reg[`TCS_CTRL_RUN0] & tick0
      & (~ctrl_reg[`TCS_CTRL_TIMER_ZERO_GATE] | I_EXT_GATE_ZERO);
    en1 = ctrl_reg[`TCS_CTRL_RUN1] & tick1 & (mode1 != TCS_MODE_SPLIT)
      & (~ctrl_reg[`TCS_CTRL_GATE1] | I_EXT_GATE_ONE);
    en_split_high = ctrl_reg[`TCS_CTRL_RUN1] & tick0;
    step0 = tcs_step(mode0, t0l_reg, t0h_reg);
    step1 = tcs_step(mode1, t1l_reg, t1h_reg);
    // Counts advance from the held value; run never clears them.
    t0l_next = t0l_reg;
    t0h_next = t0h_reg;
    t1l_next = t1l_reg;
    t1h_next = t1h_reg;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    if (mode0 == TCS_MODE_SPLIT) begin
      if (en0) begin
        {ovf0, t0l_next} = {1'b0, t0l_reg} + 9'h001;
      end
      if (en_split_high) begin
        {ovf1, t0h_next} = {1'b0, t0h_reg} + 9'h001;
      end
    end else if (en0) begin
      {ovf0, t0h_next, t0l_next} = step0;
    end
    if (en1) begin
      t1h_next = step1[15:8];
      t1l_next = step1[7:0];
      if (mode0 != TCS_MODE_SPLIT) begin
        ovf1 = step1[16];
      end
    end
    if (wr_t0l) begin
      t0l_next = I_HWDATA[7:0];
    end
    if (wr_t1l) begin
      t1l_next = I_HWDATA[7:0];
    end
    if (wr_t0h) begin
      t0h_next = I_HWDATA[7:0];
    end
    if (wr_t1h) begin
      t1h_next = I_HWDATA[7:0];
    end
    cfg_next = cfg_reg;
    if (wr_cfg) begin
      cfg_next = I_HWDATA[7:0] & `TCS_CFG_WMASK;
    end
    ctrl_next = wr_ctrl ? I_HWDATA[7:0] : ctrl_reg;
    mask_next = wr_mask ? I_HWDATA[1:0] : mask_reg;
    // Clears first, then sets, so a coincident overflow is kept.
    flag_next = flag_reg;
    if (wr_stat) begin
      flag_next = flag_next & ~I_HWDATA[1:0];
    end
    if (I_T0_VECTORED) begin
      flag_next[0] = 1'b0;
    end
    if (I_T1_VECTORED) begin
      flag_next[1] = 1'b0;
    end
    if (ovf0) begin
      flag_next[0] = 1'b1;
    end
    if (ovf1) begin
      flag_next[1] = 1'b1;
    end
    irq_next = |(flag_next & mask_next);
  end

  // ========================================================================
  // Read data, taken from post-write values so reads after writes see them
  always_comb begin
    hrdata_next = 32'h00000000;
    if (!rd_acc) begin
      hrdata_next = 32'h00000000;
    end else if (rd_idx == `TCS_IDX_T0_LOW) begin
      hrdata_next = {24'h000000, t0l_next};
    end else if (rd_idx == `TCS_IDX_T1_LOW) begin
      hrdata_next = {24'h000000, t1l_next};
    end else if (rd_idx == `TCS_IDX_T0_HIGH) begin
      hrdata_next = {24'h000000, t0h_next};
    end else if (rd_idx == `TCS_IDX_T1_HIGH) begin
      hrdata_next = {24'h000000, t1h_next};
    end else if (rd_idx == `TCS_IDX_CLK_CFG) begin
      hrdata_next = {28'h0000000, cfg_next[3:0]};
    end else if (rd_idx == `TCS_IDX_TIMER_CTRL) begin
      hrdata_next = {24'h000000, ctrl_next};
    end else if (rd_idx == `TCS_IDX_IRQ_STATUS) begin
      hrdata_next = {30'h00000000, flag_next};
    end else if (rd_idx == `TCS_IDX_IRQ_MASK) begin
      hrdata_next = {30'h00000000, mask_next};
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      t0l_reg <= `TCS_RST_BYTE;
      t0h_reg <= `TCS_RST_BYTE;
      t1l_reg <= `TCS_RST_BYTE;
      t1h_reg <= `TCS_RST_BYTE;
      cfg_reg <= `TCS_RST_BYTE;
      ctrl_reg <= `TCS_RST_BYTE;
      flag_reg <= `TCS_RST_FLAGS;
      mask_reg <= `TCS_RST_FLAGS;
      irq_reg <= 1'b0;
      hrdata_reg <= 32'h00000000;
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end else begin
      t0l_reg <= t0l_next;
      t0h_reg <= t0h_next;
      t1l_reg <= t1l_next;
      t1h_reg <= t1h_next;
      cfg_reg <= cfg_next;
      ctrl_reg <= ctrl_next;
      flag_reg <= flag_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      hrdata_reg <= hrdata_next;
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
    end
  end

  assign O_HRDATA = hrdata_reg;
  assign O_HREADYOUT = hready_reg;
  assign O_HRESP = hresp_reg;
  assign O_T0_OVERFLOW_FLAG = flag_reg[0];
  assign O_T1_OVERFLOW_FLAG = flag_reg[1];
  assign O_IRQ = irq_reg;

  // ========================================================================
  // Checks
  property p_cfg_upper_zero;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
    (rd_acc && rd_idx == `TCS_IDX_CLK_CFG) |=> (O_HRDATA[31:4] == 28'h0);
  endproperty
  a_cfg_upper_zero: assert property (p_cfg_upper_zero)
    else $error("Clock config upper bits not zero.");

  property p_cfg_reset;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
    $fell(I_SRST) |-> (cfg_reg == 8'h00 && t1h_reg == 8'h00);
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("Clock config or count not zero after reset.");

  property p_t0_sysclk;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
    (cfg_reg[2] && ctrl_reg[0] && !ctrl_reg[1]) |-> en0;
  endproperty
  a_t0_sysclk: assert property (p_t0_sysclk)
    else $error("Timer zero not counting on system clock.");

  property p_t1_prescaled;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
    (!cfg_reg[3] && !pre_tick) |-> !en1;
  endproperty
  a_t1_prescaled: assert property (p_t1_prescaled)
    else $error("Timer one counted without a prescaled tick.");

  property p_stopped_holds;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
    (!ctrl_reg[0] && mode0 != TCS_MODE_SPLIT && !wr_t0l && !wr_t0h)
      |=> ($stable(t0l_reg) && $stable(t0h_reg));
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("Stopped timer zero changed its count.");

  property p_reload;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
    (mode0 == TCS_MODE_RELOAD && en0 && t0l_reg == 8'hFF && !wr_t0l
      && !wr_t0h) |=> (t0l_reg == $past(t0h_reg) && flag_reg[0]);
  endproperty
  a_reload: assert property (p_reload)
    else $error("Reload or overflow flag missing.");

  property p_count16;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
    (mode0 == TCS_MODE_16BIT && en0 && !wr_t0l && !wr_t0h)
      |=> ({t0h_reg, t0l_reg} == $past({t0h_reg, t0l_reg}) + 16'h0001);
  endproperty
  a_count16: assert property (p_count16)
    else $error("Sixteen bit count did not advance by one.");

  property p_write_wins;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
    wr_t0l |=> (t0l_reg == $past(I_HWDATA[7:0]));
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("Count byte write lost.");

  property p_vector_clear;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
    (I_T0_VECTORED && !ovf0) |=> !flag_reg[0]
      ##1 (irq_reg == |(flag_reg & mask_reg));
  endproperty
  a_vector_clear: assert property (p_vector_clear)
    else $error("Overflow flag not cleared on vectoring.");

endmodule // tcs_top

// ==== tb/tcs_top_bench.sv ====
// Self-checking bench for the timer clock select and count block.
`timescale 1ns/1ps
`include "tcs_defs.svh"

module tcs_top_bench;
  // ==========================================================================
  // Signals and design instance.
  localparam logic [7:0] T0L = `TCS_IDX_T0_LOW;
  localparam logic [7:0] T1L = `TCS_IDX_T1_LOW;
  localparam logic [7:0] T0H = `TCS_IDX_T0_HIGH;
  localparam logic [7:0] T1H = `TCS_IDX_T1_HIGH;
  localparam logic [7:0] CFG = `TCS_IDX_CLK_CFG;
  localparam logic [7:0] CTL = `TCS_IDX_TIMER_CTRL;
  localparam logic [7:0] STA = `TCS_IDX_IRQ_STATUS;
  localparam logic [7:0] MSK = `TCS_IDX_IRQ_MASK;
  logic [7:0] regs [9] = '{T0L, T1L, T0H, T1H, CFG, CTL, STA, MSK, 8'h80};
  logic clk, srst, hsel, hwrite, ext_clk, timer_zero_gate, gate1, vec0, vec1;
  logic [31:0] haddr, hwdata, rdata, hrdata, hrdata_q;
  logic [1:0] htrans;
  logic hreadyout, hresp, flag0, flag1, irq, hready_q, ext_en;
  int mismatches, tests_run, ext_edges;
  int cycles = 0;

  tcs_top uut (.I_CORE_CLK(clk), .I_SRST(srst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HRDATA(hrdata),
    .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .I_EXT_CLK(ext_clk),
    .I_EXT_GATE_ZERO(timer_zero_gate), .I_EXT_GATE_ONE(gate1), .I_T0_VECTORED(vec0),
    .I_T1_VECTORED(vec1), .O_T0_OVERFLOW_FLAG(flag0),
    .O_T1_OVERFLOW_FLAG(flag1), .O_IRQ(irq));

  // ==========================================================================
  // Clock, bus sampling, external clock and timeout.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    hrdata_q <= hrdata;
    hready_q <= hreadyout;
    cycles <= cycles + 1;
    if (ext_en && (cycles % 3 == 0)) begin
      ext_clk <= ~ext_clk;
      if (ext_clk == 1'b0) begin
        ext_edges++;
      end
    end
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  // ==========================================================================
  // Bus tasks, comparisons and expectations.
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    step();
    while (hready_q !== 1'b1) step();
    htrans <= 2'h0;
    hwdata <= wd;
    step();
    while (hready_q !== 1'b1) step();
    rd = hrdata_q;
  endtask

  task automatic check(input string name, input logic [31:0] exp,
      input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic near(input string name, input logic [15:0] exp,
      input logic [15:0] seen);
    tests_run++;
    if ((seen + 16'h1 >= exp && seen <= exp + 16'h1) !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, rdata);
  endtask

  task automatic rd(input string name, input logic [7:0] idx,
      input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, rdata);
    check(name, exp, rdata);
  endtask

  task automatic load(input logic [7:0] lo, input logic [7:0] hi,
      input logic [15:0] val);
    wr(lo, {24'h0, val[7:0]});
    wr(hi, {24'h0, val[15:8]});
  endtask

  task automatic count(input logic [7:0] lo, input logic [7:0] hi,
      output logic [15:0] c);
    bus(1'b0, hi, 32'h0, rdata);
    c[15:8] = rdata[7:0];
    bus(1'b0, lo, 32'h0, rdata);
    c[7:0] = rdata[7:0];
  endtask

  task automatic run(input logic [31:0] on, input logic [31:0] off, int k);
    wr(CTL, on);
    repeat (k) step();
    wr(CTL, off);
  endtask

  function automatic logic [15:0] after(logic [15:0] start, int k);
    return start + 16'(k + 2);
  endfunction

  function automatic logic [15:0] after13(logic [15:0] s, int n);
    logic [12:0] c;
    c = {s[15:8], s[4:0]} + 13'(n);
    return {c[12:5], s[7:5], c[4:0]};
  endfunction

  function automatic logic [15:0] split_after(logic [15:0] s, int n);
    return {s[15:8] + 8'(n), s[7:0] + 8'(n)};
  endfunction

  function automatic int div_of(int code);
    case (code)
      0: return 12;
      1: return 4;
      2: return 48;
      default: return 8;
    endcase
  endfunction

  task automatic test_done();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    logic [31:0] v;
    logic [15:0] c0, c1;
    int k;
    {srst, hsel, hwrite, ext_clk, timer_zero_gate, gate1, vec0, vec1} = 8'h80;
    {haddr, hwdata, htrans, ext_en, ext_edges} = '0;
    mismatches = 0;
    tests_run = 0;
    v = $urandom(81);
    repeat (8) step();
    srst <= 1'b0;
    step();
    wr(8'h80, 32'hFF);
    foreach (regs[i]) rd("reset value", regs[i], 32'h0);
    check("response", 32'h0, {31'h0, hresp});
    check("ready", 32'h1, {31'h0, hreadyout});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom();
      wr(regs[i], v);
      rd("count byte", regs[i], {24'h0, v[7:0]});
    end
    v = $urandom() | 32'hF0;
    wr(CFG, v);
    rd("clock config", CFG, v & 32'h0F);
    $display("test access done");
    wr(CFG, 32'h0C);
    for (int i = 0; i < 3; i++) begin
      k = 10 + int'($urandom() % 30);
      v = $urandom() | 32'h00F8_00F8;
      load(T0L, T0H, v[15:0]);
      load(T1L, T1H, v[31:16]);
      run(32'h55, 32'h44, k);
      count(T0L, T0H, c0);
      count(T1L, T1H, c1);
      check("timer zero count", after(v[15:0], k), c0);
      check("timer one count", after(v[31:16], k), c1);
    end
    $display("test system clock done");
    for (int code = 0; code < 4; code++) begin
      wr(CFG, 32'h08 | code);
      load(T0L, T0H, 16'h0);
      load(T1L, T1H, 16'h0);
      ext_edges = 0;
      ext_en = (code == 3);
      run(32'h55, 32'h44, 470);
      ext_en = 1'b0;
      count(T0L, T0H, c0);
      count(T1L, T1H, c1);
      check("unprescaled timer", after(16'h0, 470), c1);
      if (code == 3) begin
        near("external ticks", 16'(ext_edges / 8), c0);
      end else begin
        near("prescaled ticks", 16'(472 / div_of(code)), c0);
      end
    end
    $display("test prescaler done");
    wr(CFG, 32'h0C);
    for (int g = 0; g < 2; g++) begin
      timer_zero_gate <= g[0];
      gate1 <= g[0];
      load(T0L, T0H, 16'h0);
      load(T1L, T1H, 16'h0);
      run(32'h77, 32'h44, 20);
      count(T0L, T0H, c0);
      count(T1L, T1H, c1);
      check("gated timer zero", g ? 16'd22 : 16'd0, c0);
      check("gated timer one", g ? 16'd22 : 16'd0, c1);
    end
    $display("test gate done");
    for (int i = 0; i < 2; i++) begin
      k = 10 + int'($urandom() % 30);
      v = $urandom();
      load(T0L, T0H, v[15:0]);
      load(T1L, T1H, v[31:16]);
      run(32'h11, 32'h00, k);
      count(T0L, T0H, c0);
      count(T1L, T1H, c1);
      check("13 bit timer zero", after13(v[15:0], k + 2), c0);
      check("13 bit timer one", after13(v[31:16], k + 2), c1);
    end
    $display("test 13 bit done");
    k = 10 + int'($urandom() % 30);
    v = ($urandom() & 32'h7F00) | 32'hF8;
    wr(STA, 32'h3);
    load(T0L, T0H, v[15:0]);
    load(T1L, T1H, 16'hFFF8);
    run(32'h5D, 32'h4C, k);
    count(T0L, T0H, c0);
    count(T1L, T1H, c1);
    check("split timer zero", split_after(v[15:0], k + 2), c0);
    check("split timer one", after(16'hFFF8, k), c1);
    check("split flags", 32'h1, {30'h0, flag1, flag0});
    $display("test split done");
    v = 32'hF0 + ($urandom() % 10);
    load(T0L, T0H, {v[7:0], 8'hFD});
    load(T1L, T1H, {v[7:0], 8'hFD});
    run(32'h99, 32'h88, 5);
    count(T0L, T0H, c0);
    check("reload count", {v[7:0], v[7:0] + 8'h4}, c0);
    check("flags set", 32'h3, {30'h0, flag1, flag0});
    check("masked irq", 32'h0, {31'h0, irq});
    rd("status", STA, 32'h3);
    wr(MSK, 32'h1);
    step();
    step();
    check("irq raised", 32'h1, {31'h0, irq});
    wr(STA, 32'h1);
    step();
    step();
    check("flags after clear", 32'h2, {30'h0, flag1, flag0});
    check("irq cleared", 32'h0, {31'h0, irq});
    load(T0L, T0H, {v[7:0], 8'hFF});
    run(32'h99, 32'h88, 0);
    check("flag zero again", 32'h1, {31'h0, flag0});
    vec0 <= 1'b1;
    vec1 <= 1'b1;
    step();
    vec0 <= 1'b0;
    vec1 <= 1'b0;
    step();
    check("flags after vector", 32'h0, {30'h0, flag1, flag0});
    $display("test flags done");
    test_done();
  end
endmodule // tcs_top_bench
